// >>> design/cas_params.svh
`ifndef CAS_PARAMS_SVH
`define CAS_PARAMS_SVH
`define CAS_BIT_DMO        0
`define CAS_BIT_LOS        1
`define CAS_BIT_LOL        2
`define CAS_BIT_FIFO_LIMIT 3
`define CAS_BIT_ALOS       4
`define CAS_BIT_DLOS       5
`define CAS_BIT_PRBS       6
`define CAS_STATUS_RESET   8'h00
`define CAS_DLOS_ZERO_RUN  160
`define CAS_DLOS_WIN       9
`define CAS_DLOS_MIN_ONES  3
`define CAS_LIMIT_MARGIN   2
`define CAS_FIFO_DEPTH     32
`endif

// >>> design/cas_pkg.sv
package cas_pkg;
  typedef enum logic [1:0] {CAS_MODE_DS3, CAS_MODE_STS1, CAS_MODE_E3} cas_mode_t;
  // raw per-channel conditions from the analog front end and neighbouring blocks
  typedef struct packed {
    logic alos_below_decl;
    logic alos_above_clr;
    logic e3_los;
    logic prbs_unlock;
    logic lol;
    logic dmo;
  } cas_cond_t;
endpackage : cas_pkg

// >>> design/cas_dlos_det.sv
`timescale 1ns/10ps
`include "cas_params.svh"
module cas_dlos_det #(
  parameter int ZERO_RUN = `CAS_DLOS_ZERO_RUN,
  parameter int WIN      = `CAS_DLOS_WIN,
  parameter int MIN_ONES = `CAS_DLOS_MIN_ONES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // bit stream
  input  wire logic bit_en,
  input  wire logic pulse,
  input  wire logic active,
  // result
  output logic      dlos_q
);
  logic [7:0] zrun_q, zrun_d;
  logic [3:0] wpos_q, wpos_d;
  logic [3:0] ones_q, ones_d;
  logic       dlos_d;

  always_comb begin
    zrun_d = zrun_q;
    wpos_d = wpos_q;
    ones_d = ones_q;
    dlos_d = dlos_q;
    if (!active) begin
      zrun_d = 8'h00;
      wpos_d = 4'h0;
      ones_d = 4'h0;
      dlos_d = 1'b0;
    end else if (bit_en) begin
      // declare after a run of pulse-free bit periods
      if (pulse) begin
        zrun_d = 8'h00;
      end else if (zrun_q != 8'(ZERO_RUN)) begin
        zrun_d = zrun_q + 8'h01;
      end
      if (!pulse && zrun_q == 8'(ZERO_RUN - 1)) begin
        dlos_d = 1'b1; // RULE12
      end
      // clear on one-third density measured over fixed windows
      ones_d = ones_q + {3'h0, pulse};
      wpos_d = wpos_q + 4'h1;
      if (wpos_q == 4'(WIN - 1)) begin
        if (ones_q + {3'h0, pulse} >= 4'(MIN_ONES)) begin
          dlos_d = 1'b0; // RULE12
        end
        wpos_d = 4'h0;
        ones_d = 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      zrun_q <= 8'h00;
      wpos_q <= 4'h0;
      ones_q <= 4'h0;
      dlos_q <= 1'b0;
    end else begin
      zrun_q <= zrun_d;
      wpos_q <= wpos_d;
      ones_q <= ones_d;
      dlos_q <= dlos_d;
    end
  end
endmodule : cas_dlos_det

// >>> design/cas_alarm_status.sv
`timescale 1ns/10ps
`include "cas_params.svh"
// Operation
// RULE1 - in DS3/STS-1, analog loss declares when amplitude falls below declare level
// RULE2 - in DS3/STS-1, analog loss clears when amplitude rises above clear level
// RULE3 - separate declare and clear levels give hysteresis; between them state holds
// RULE4 - bit 4 shows the analog loss defect state
// RULE5 - channel loss is analog defect OR digital defect
// RULE6 - bit 1 shows the combined channel loss state
// RULE7 - FIFO-limit alarm raised when fill within two bits of overflow or underrun
// RULE8 - FIFO-limit alarm dropped once fill leaves both two-bit margins
// RULE9 - bit 3 shows the FIFO-limit alarm
// RULE10 - FIFO-limit bit meaningful only with jitter attenuator enabled
// RULE11 - alarm bits are read-only live state; writes do nothing
// RULE12 - digital loss declares after pulse-free run, clears at one-third density
// RULE13 - in E3, channel loss follows the E3 loss detector instead
// RULE14 - amplitude compare arrives as comparator levels; logic selects and registers
module cas_alarm_status
  import cas_pkg::*;
#(
  parameter int FIFO_DEPTH = `CAS_FIFO_DEPTH,
  parameter int LIMIT_MARGIN = `CAS_LIMIT_MARGIN,
  parameter int FILL_W     = $clog2(FIFO_DEPTH + 1)
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // channel configuration
  input  wire cas_pkg::cas_mode_t mode,
  input  wire logic              jat_enable,
  // line side
  input  wire logic              bit_en,
  input  wire logic              rx_pulse,
  input  wire cas_pkg::cas_cond_t cond_async,
  // jitter attenuator fill level, same clock
  input  wire logic [FILL_W-1:0] jat_fill,
  // register read port
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  output logic [7:0]             reg_rdata_q,
  // live flags
  output logic                   chan_los_q,
  output logic                   fifo_limit_alarm_q
);
  import cas_pkg::*;

  cas_cond_t  sync1_q, sync2_q;
  logic       alos_q, alos_d;
  logic       limit_d, los_d;
  logic       dlos;
  logic       ds_mode;
  logic [7:0] status;
  logic [7:0] rdata_d;

  // front-end levels are from another domain; two stages before use
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= cond_async;
      sync2_q <= sync1_q;
    end
  end

  assign ds_mode = (mode != CAS_MODE_E3);

  cas_dlos_det u_dlos (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .bit_en   (bit_en),
    .pulse    (rx_pulse),
    .active   (ds_mode),
    .dlos_q   (dlos)
  );

  always_comb begin
    alos_d = alos_q; // RULE3
    if (!ds_mode) begin
      alos_d = 1'b0;
    end else if (sync2_q.alos_below_decl) begin // RULE14
      alos_d = 1'b1; // RULE1
    end else if (sync2_q.alos_above_clr) begin
      alos_d = 1'b0; // RULE2
    end
    // neither comparator active: hold, so noise near one level cannot chatter
    los_d = ds_mode ? (alos_d | dlos) : sync2_q.e3_los; // RULE5 RULE13
    // margin check against both ends; forced low while the attenuator is off so no stale alarm shows
    limit_d = jat_enable &&
              ((jat_fill <= FILL_W'(LIMIT_MARGIN)) ||
               (jat_fill >= FILL_W'(FIFO_DEPTH - LIMIT_MARGIN))); // RULE7 RULE8 RULE10
  end

  always_comb begin
    status = `CAS_STATUS_RESET;
    status[`CAS_BIT_DMO]  = sync2_q.dmo;
    status[`CAS_BIT_LOS]  = chan_los_q; // RULE6
    status[`CAS_BIT_LOL]  = sync2_q.lol;
    status[`CAS_BIT_FIFO_LIMIT] = fifo_limit_alarm_q; // RULE9
    status[`CAS_BIT_ALOS] = alos_q; // RULE4
    status[`CAS_BIT_DLOS] = dlos;
    status[`CAS_BIT_PRBS] = sync2_q.prbs_unlock;
    // reg_wr is accepted and discarded; no bit is latched
    rdata_d = reg_rd ? status : reg_rdata_q; // RULE11
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alos_q      <= 1'b0;
      chan_los_q  <= 1'b0;
      fifo_limit_alarm_q <= 1'b0;
      reg_rdata_q <= `CAS_STATUS_RESET;
    end else begin
      alos_q      <= alos_d;
      chan_los_q  <= los_d;
      fifo_limit_alarm_q <= limit_d;
      reg_rdata_q <= rdata_d;
    end
  end
endmodule : cas_alarm_status

// >>> bench/cas_alarm_status_assertions.sv
`timescale 1ns/10ps
module cas_alarm_status_chk
  import cas_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int LIMIT_MARGIN = 2,
  parameter int FILL_W     = 6
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              sys_rst,
  // inputs watched
  input wire cas_mode_t         mode,
  input wire logic              jat_enable,
  input wire cas_cond_t         cond_async,
  input wire logic [FILL_W-1:0] jat_fill,
  input wire logic              reg_rd,
  // outputs watched
  input wire logic [7:0]        reg_rdata_q,
  input wire logic              chan_los_q,
  input wire logic              fifo_limit_alarm_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // pipelines still hold reset values for a few edges after release
  logic [2:0] up_q;
  always_ff @(posedge core_clk) up_q <= sys_rst ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  wire ok = up_q == 3'h7;
  wire ds = mode != CAS_MODE_E3;
  a_limit_raise: assert property (ok && jat_enable &&
    (jat_fill <= LIMIT_MARGIN || jat_fill >= FIFO_DEPTH - LIMIT_MARGIN)
    |=> fifo_limit_alarm_q) else $error("fifo limit alarm missing");
  a_limit_drop: assert property (ok && jat_fill > LIMIT_MARGIN &&
    jat_fill < FIFO_DEPTH - LIMIT_MARGIN |=> !fifo_limit_alarm_q) else $error("fifo limit alarm stuck");
  a_limit_disabled: assert property (ok && !jat_enable |=> !fifo_limit_alarm_q)
    else $error("alarm while disabled");
  a_rd_limit_bit: assert property (reg_rd ##1 $stable(fifo_limit_alarm_q) |->
    reg_rdata_q[3] == fifo_limit_alarm_q) else $error("bit 3 differs from alarm");
  a_rd_los_bit: assert property (reg_rd ##1 $stable(chan_los_q) |-> reg_rdata_q[1] == chan_los_q)
    else $error("bit 1 differs from loss");
  a_rd_stands: assert property (ok && !reg_rd |=> $stable(reg_rdata_q)) else $error("status moved");
  a_los_e3: assert property (ok ##0 (mode == CAS_MODE_E3) [*4] |->
    chan_los_q == $past(cond_async.e3_los, 3)) else $error("e3 loss not followed");
  a_los_analog: assert property (ok ##0 (ds && cond_async.alos_below_decl) [*4] |-> chan_los_q)
    else $error("analog loss not in channel loss");
  a_alos_set: assert property (ok ##0 (ds && cond_async.alos_below_decl) [*4] ##0 reg_rd
    |=> reg_rdata_q[4]) else $error("bit 4 not set");
  a_alos_clr: assert property (ok ##0
    (ds && cond_async.alos_above_clr && !cond_async.alos_below_decl) [*4]
    ##0 reg_rd |=> !reg_rdata_q[4]) else $error("bit 4 not cleared");
  c_limit: cover property (jat_enable ##1 fifo_limit_alarm_q);
  c_e3: cover property (mode == CAS_MODE_E3 && chan_los_q);
  c_alos: cover property (reg_rd ##1 reg_rdata_q[4]);
endmodule : cas_alarm_status_chk
bind cas_alarm_status cas_alarm_status_chk #(
  .FIFO_DEPTH(FIFO_DEPTH), .LIMIT_MARGIN(LIMIT_MARGIN), .FILL_W(FILL_W)) u_chk (
  .core_clk, .sys_rst, .mode, .jat_enable, .cond_async, .jat_fill, .reg_rd, .reg_rdata_q, .chan_los_q,
  .fifo_limit_alarm_q);

// >>> bench/tb_cas_alarm_status.sv
`timescale 1ns/10ps
module tb_cas_alarm_status;
  import cas_pkg::*;
  logic       core_clk, sys_rst, jat_enable, bit_en, rx_pulse, reg_rd, reg_wr, chan_los_q, fifo_limit_alarm_q, e;
  cas_mode_t  mode;
  cas_cond_t  cond_async;
  logic [5:0] jat_fill;
  logic [7:0] reg_rdata_q;
  int         failures, compares;
  // each row: enable, expected alarm, fill level
  logic [7:0] rows [8] = '{8'hC0, 8'hC2, 8'h83, 8'h9D, 8'hDE, 8'hE0, 8'h00, 8'h1F};
  cas_alarm_status u_cas_alarm_status (.core_clk, .sys_rst, .mode, .jat_enable, .bit_en, .rx_pulse,
    .cond_async, .jat_fill, .reg_rd, .reg_wr, .reg_rdata_q, .chan_los_q, .fifo_limit_alarm_q);
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  task tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task chk(string n, logic [7:0] x, logic [7:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task rd;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    tick(1);
  endtask : rd
  // move the comparators, let the sync pipe settle, then read bits 4 and 1
  task step(logic b, logic a, logic [1:0] x);
    cond_async.alos_below_decl = b;
    cond_async.alos_above_clr = a;
    tick(5);
    rd;
    chk("alos_los", x, {reg_rdata_q[4], reg_rdata_q[1]});
  endtask : step
  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    {sys_rst, bit_en, rx_pulse, jat_fill} = {3'h7, 6'h10};
    {jat_enable, reg_rd, reg_wr, failures, compares} = '0;
    mode = CAS_MODE_DS3;
    cond_async = '0;
    tick(10);
    chk("rst", 8'h00, {reg_rdata_q[7:2], chan_los_q, fifo_limit_alarm_q});
    sys_rst = 0;
    tick(8);
    foreach (rows[i]) begin
      {jat_enable, e, jat_fill} = rows[i];
      tick(2);
      chk("limit", e, fifo_limit_alarm_q);
      rd;
      chk("bit3", e, reg_rdata_q[3]);
    end
    {jat_enable, jat_fill} = 7'h40;
    tick(3);
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(1);
    chk("wr", 8'h00, reg_rdata_q);
    rd;
    chk("wr_live", 8'h08, reg_rdata_q);
    jat_enable = 0;
    for (int m = 0; m < 2; m++) begin
      mode = cas_mode_t'(m);
      step(1, 0, 2'h3);
      step(0, 0, 2'h3);
      step(0, 1, 2'h0);
      step(0, 0, 2'h0);
    end
    mode = CAS_MODE_E3;
    step(1, 0, 2'h0);
    cond_async.e3_los = 1;
    step(1, 0, 2'h1);
    cond_async = '0;
    // flush the old comparator levels out of the synchroniser before the detectors wake
    tick(3);
    mode = CAS_MODE_DS3;
    rx_pulse = 0;
    tick(150);
    chk("dlos_early", 1'b0, chan_los_q);
    tick(20);
    chk("dlos", 1'b1, chan_los_q);
    rx_pulse = 1;
    tick(30);
    chk("dlos_clr", 1'b0, chan_los_q);
    // mid-run reset while the digital detector declares; its count must restart
    rx_pulse = 0;
    tick(170);
    chk("dlos_again", 1'b1, chan_los_q);
    sys_rst = 1;
    tick(2);
    chk("rst_los", 1'b0, chan_los_q);
    chk("rst_rdata", 8'h00, reg_rdata_q);
    sys_rst = 0;
    tick(150);
    chk("dlos_restart", 1'b0, chan_los_q);
    print_verdict;
  end
endmodule : tb_cas_alarm_status
